/* File: ptc_ext_src.sv */
// Model of the external trigger and gate source on the trigger input.
module ptc_ext_src
	#(
	parameter int PW = 2 // Pulse width in clock cycles.
	)
	(
	// Clock.
	input  wire logic aclk,
	// Requests from the bench.
	input  wire logic pulse_req,
	input  wire logic gate_on,
	input  wire logic gate_low,
	// Line to the device.
	output logic      ext_trig
	);
	timeunit 1ns;
	timeprecision 1ps;

	int left = 0; // Cycles of the running pulse still to go.

	// ==============================================================
	// Pulse timer
	// A pulse begins just after the edge that sees a request.
	always @(posedge aclk)
	begin
		if (pulse_req)
			left <= PW;
		else if (left != 0)
			left <= left - 1;
	end

	// The line rests low, as if pulled down; a low gate rests high.
	assign ext_trig = gate_low ? !gate_on : (gate_on || left != 0);
endmodule

/* File: ptc_pkg.sv */
// Constants and types shared by the playback trigger block.
package ptc_pkg;

	// ==============================================================
	// Register map (byte addresses)
	localparam logic [7:0] OFS_CTRL   = 8'h00; // Mode and source.
	localparam logic [7:0] OFS_BBLEN  = 8'h04; // Baseband pass length.
	localparam logic [7:0] OFS_SEGLEN = 8'h08; // Segment length, count.
	localparam logic [7:0] OFS_TRIG   = 8'h0c; // Bus trigger strobes.
	localparam logic [7:0] OFS_STAT   = 8'h10; // Playback state.
	localparam logic [7:0] OFS_IPER   = 8'h14; // Internal trigger period.

	// ==============================================================
	// Field positions
	localparam int CTL_BB_EN  = 0;  // Baseband path enable.
	localparam int CTL_ARB_EN = 1;  // Arbitrary path enable.
	localparam int CTL_BBM    = 2;  // Baseband mode, two bits.
	localparam int CTL_BBS    = 4;  // Baseband source, two bits.
	localparam int CTL_POL    = 6;  // External edge polarity.
	localparam int CTL_ARBM   = 8;  // Arbitrary mode, three bits.
	localparam int CTL_ARBS   = 12; // Arbitrary source, two bits.
	localparam int TRG_BB     = 0;  // Bus trigger for baseband.
	localparam int TRG_ARB    = 1;  // Bus trigger for arbitrary.
	localparam int SEG_NUM    = 16; // Segment count, four bits.

	// ==============================================================
	// Reset values
	localparam logic [31:0] CTRL_RST   = 32'h0000_0040;
	localparam logic [15:0] BBLEN_RST  = 16'h0100;
	localparam logic [19:0] SEGLEN_RST = 20'h4_0100;
	localparam logic [31:0] IPER_RST   = 32'h0000_03e8;

	// ==============================================================
	// Sizes and bus answers
	localparam int         FIFO_DEPTH  = 16;
	localparam int         SMP_W       = 32;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ==============================================================
	// Types
	typedef enum logic [1:0] {
		BB_CONT, BB_SINGLE, BB_GATE_HI, BB_GATE_LO
	} ptc_bbm_e;
	typedef enum logic [1:0] {
		SRC_KEY, SRC_EXT, SRC_BUS, SRC_INT
	} ptc_src_e;
	typedef enum logic [2:0] {
		ARB_CONT_RT, ARB_IGNORE, ARB_BUFFER, ARB_SINGLE_RT,
		ARB_SEGMENT, ARB_GATE_HI
	} ptc_arbm_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_PLAY = 2'b01, ST_GATED = 2'b11
	} ptc_state_e;
	typedef struct packed {
		logic [15:0] q; // Quadrature sample.
		logic [15:0] i; // In-phase sample.
	} ptc_smp_s;

endpackage

/* File: ptc_trigger.sv */
// Playback trigger control with its sample FIFO and register slave.

// ==================================================================
// Sample FIFO
module ptc_fifo
	#(
	parameter int W     = 32,
	parameter int DEPTH = 16
	)
	(
	// Clock and reset.
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Filling side.
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side.
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
	);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH]; // Storage; depth is a power of two.
	logic [AW-1:0] wr_ptr_reg;  // Next slot to fill.
	logic [AW-1:0] rd_ptr_reg;  // Oldest stored word.
	logic [AW:0]   cnt_reg;     // Words held.
	wire           push = in_valid && in_ready;
	wire           pop  = out_valid && out_ready;

	assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem[rd_ptr_reg];

	// Pointers wrap naturally because the depth is a power of two.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			cnt_reg    <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage needs no reset.
	always_ff @(posedge aclk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end
endmodule

// ==================================================================
// Trigger control top
module ptc_trigger
	import ptc_pkg::*;
	(
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Register bus, write side.
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// Register bus, read side.
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Trigger inputs.
	input  wire logic        key_press,
	input  wire logic        ext_trig,
	// Sample stream in.
	input  wire logic        s_valid,
	output logic             s_ready,
	input  wire ptc_smp_s    s_data,
	// Sample stream out.
	output logic             out_valid,
	output ptc_smp_s         out_smp,
	output logic [3:0]       seg_index
	);

	// Merges written bytes into an old register value.
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] val,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				res[8*b +: 8] = val[8*b +: 8];
		return res;
	endfunction

	// ==============================================================
	// Register slave
	logic        aw_hold_reg;  // Write address held.
	logic        w_hold_reg;   // Write data held.
	logic [7:0]  wr_addr_reg;  // Held write address.
	logic [31:0] wdata_reg;    // Held write data.
	logic [3:0]  wstrb_reg;    // Held byte enables.
	logic        bvalid_reg;   // Write answer pending.
	logic [1:0]  bresp_reg;    // Write answer code.
	logic        rvalid_reg;   // Read answer pending.
	logic [31:0] rdata_reg;    // Read answer data.
	logic [1:0]  rresp_reg;    // Read answer code.
	logic [31:0] ctrl_reg;     // Modes and sources.
	logic [15:0] bblen_reg;    // Baseband samples per pass.
	logic [19:0] seglen_reg;   // Segment length and count.
	logic [31:0] iper_reg;     // Internal trigger period.
	logic [1:0]  bus_trig_reg; // One-cycle bus triggers.
	logic [31:0] rd_val;       // Decoded read value.
	logic        rd_hit;       // Read address is mapped.
	logic [31:0] stat_val;     // Status word.

	assign awready = !aw_hold_reg && !bvalid_reg;
	assign wready  = !w_hold_reg && !bvalid_reg;
	assign bvalid  = bvalid_reg;
	assign bresp   = bresp_reg;
	assign arready = !rvalid_reg;
	assign rvalid  = rvalid_reg;
	assign rdata   = rdata_reg;
	assign rresp   = rresp_reg;

	wire do_wr    = aw_hold_reg && w_hold_reg && !bvalid_reg;
	wire wr_ctrl  = do_wr && (wr_addr_reg == OFS_CTRL);
	wire wr_bblen = do_wr && (wr_addr_reg == OFS_BBLEN);
	wire wr_seg   = do_wr && (wr_addr_reg == OFS_SEGLEN);
	wire wr_trig  = do_wr && (wr_addr_reg == OFS_TRIG);
	wire wr_iper  = do_wr && (wr_addr_reg == OFS_IPER);
	wire wr_hit   = wr_ctrl || wr_bblen || wr_seg || wr_trig
		|| wr_iper || (wr_addr_reg == OFS_STAT);
	wire [31:0] ctrl_v  = merge(ctrl_reg, wdata_reg, wstrb_reg);
	wire [31:0] bblen_v = merge({16'h0, bblen_reg}, wdata_reg,
		wstrb_reg);
	wire [31:0] seg_v   = merge({12'h0, seglen_reg}, wdata_reg,
		wstrb_reg);
	wire [31:0] iper_v  = merge(iper_reg, wdata_reg, wstrb_reg);

	// Address and data are taken in either order, then written.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			wr_addr_reg <= '0;
			wdata_reg   <= '0;
			wstrb_reg   <= '0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_hold_reg <= 1'b1;
				wr_addr_reg <= awaddr;
			end
			else if (do_wr)
				aw_hold_reg <= 1'b0;
			if (wvalid && wready)
			begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= wdata;
				wstrb_reg  <= wstrb;
			end
			else if (do_wr)
				w_hold_reg <= 1'b0;
			if (do_wr)
			begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bready)
				bvalid_reg <= 1'b0;
		end
	end

	// Configuration registers; the status word is read-only.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_reg     <= CTRL_RST;
			bblen_reg    <= BBLEN_RST;
			seglen_reg   <= SEGLEN_RST;
			iper_reg     <= IPER_RST;
			bus_trig_reg <= 2'b00;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= ctrl_v;
			if (wr_bblen)
				bblen_reg <= bblen_v[15:0];
			if (wr_seg)
				seglen_reg <= seg_v[19:0];
			if (wr_iper)
				iper_reg <= iper_v;
			bus_trig_reg <= (wr_trig && wstrb_reg[0])
				? wdata_reg[1:0] : 2'b00;
		end
	end

	// Read address decode.
	always_comb
	begin
		rd_hit = 1'b1;
		if (araddr == OFS_CTRL)
			rd_val = ctrl_reg;
		else if (araddr == OFS_BBLEN)
			rd_val = {16'h0, bblen_reg};
		else if (araddr == OFS_SEGLEN)
			rd_val = {12'h0, seglen_reg};
		else if (araddr == OFS_TRIG)
			rd_val = '0;
		else if (araddr == OFS_STAT)
			rd_val = stat_val;
		else if (araddr == OFS_IPER)
			rd_val = iper_reg;
		else
		begin
			rd_val = '0;
			rd_hit = 1'b0;
		end
	end

	// Read answer one cycle after the address is taken.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_val;
			rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rready)
			rvalid_reg <= 1'b0;
	end

	// ==============================================================
	// Trigger selection
	ptc_state_e  state_reg, state_next; // Playback state.
	logic [15:0] pos_reg, pos_next;     // Sample within the pass.
	logic        pend_reg;              // Buffered retrigger.
	logic [3:0]  seg_reg;               // Current segment.
	logic        ext_q_reg;             // Last external level.
	logic [31:0] int_cnt_reg;           // Internal trigger timer.
	logic        f_valid;               // FIFO holds a sample.
	ptc_smp_s    f_data;                // FIFO head sample.
	logic        trig;                  // Selected trigger event.

	wire        bb_en   = ctrl_reg[CTL_BB_EN];
	wire        arb_sel = ctrl_reg[CTL_ARB_EN];
	wire        run_en  = bb_en || arb_sel;
	wire ptc_bbm_e  bbm  = ptc_bbm_e'(ctrl_reg[CTL_BBM +: 2]);
	wire ptc_arbm_e arbm = ptc_arbm_e'(ctrl_reg[CTL_ARBM +: 3]);
	wire        bb_gate  = !arb_sel && (bbm == BB_GATE_HI
		|| bbm == BB_GATE_LO);
	wire        arb_gate = arb_sel && (arbm == ARB_GATE_HI);
	wire        gate_mode = bb_gate || arb_gate;
	wire        gate_lo   = bb_gate && (bbm == BB_GATE_LO);
	wire        gate_open = gate_lo ? !ext_trig : ext_trig;
	wire        cont = !arb_sel && (bbm == BB_CONT);
	wire        wrap = cont || gate_mode;
	wire ptc_src_e src = gate_mode ? SRC_EXT : ptc_src_e'(arb_sel
		? ctrl_reg[CTL_ARBS +: 2] : ctrl_reg[CTL_BBS +: 2]);
	wire        ext_lvl  = ctrl_reg[CTL_POL] ? ext_trig : !ext_trig;
	wire        ext_rise = ext_lvl && !ext_q_reg;
	// A shortened period must not leave the timer above its end point.
	wire        int_ev   = (int_cnt_reg >= iper_reg - 32'h1);
	wire        bus_ev   = arb_sel ? bus_trig_reg[TRG_ARB]
		: bus_trig_reg[TRG_BB];
	wire [15:0] len      = arb_sel ? seglen_reg[15:0] : bblen_reg;
	wire [3:0]  nseg     = seglen_reg[SEG_NUM +: 4];

	// Source multiplexer; baseband has no internal source.
	always_comb
	begin
		case (src)
		SRC_KEY: trig = key_press;
		SRC_EXT: trig = ext_rise;
		SRC_BUS: trig = bus_ev;
		default: trig = arb_sel && int_ev;
		endcase
		trig = trig && run_en;
	end

	// ==============================================================
	// Playback
	wire play_now = (state_reg == ST_PLAY) && run_en
		&& !(gate_mode && !gate_open);
	wire pop      = play_now && f_valid;
	wire last     = pop && (pos_reg == len - 16'h1);
	wire restart  = trig && arb_sel && (arbm == ARB_CONT_RT
		|| arbm == ARB_SINGLE_RT);
	wire buf_mode = arb_sel && (arbm == ARB_BUFFER);
	wire pend_set = buf_mode && trig && (state_reg != ST_IDLE);
	wire start    = (state_reg == ST_IDLE) && (state_next == ST_PLAY);

	ptc_fifo #(.W(SMP_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (s_valid),
		.in_ready  (s_ready),
		.in_data   (s_data),
		.out_valid (f_valid),
		.out_ready (pop),
		.out_data  (f_data)
	);

	// Next state; triggers in baseband single, arbitrary ignore and segment modes are ignored while playing.
	always_comb
	begin
		state_next = state_reg;
		pos_next   = pos_reg;
		if (pop)
			pos_next = last ? '0 : pos_reg + 16'h1;
		case (state_reg)
		ST_IDLE:
		begin
			pos_next = '0;
			if (run_en && (gate_mode ? gate_open
				: (cont || trig || pend_reg)))
				state_next = ST_PLAY;
		end
		ST_PLAY:
		begin
			if (!run_en)
				state_next = ST_IDLE;
			else if (gate_mode && !gate_open)
				state_next = ST_GATED;
			else if (restart)
				pos_next = '0;
			else if (last && !wrap && !pend_reg)
				state_next = ST_IDLE;
		end
		ST_GATED:
		begin
			if (!run_en)
				state_next = ST_IDLE;
			else if (gate_open)
				state_next = ST_PLAY;
		end
		default: state_next = ST_IDLE;
		endcase
	end

	// Playback registers; a new buffered trigger beats its clear.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg   <= ST_IDLE;
			pos_reg     <= '0;
			pend_reg    <= 1'b0;
			seg_reg     <= '0;
			ext_q_reg   <= 1'b0;
			int_cnt_reg <= '0;
		end
		else
		begin
			state_reg   <= state_next;
			pos_reg     <= pos_next;
			pend_reg    <= pend_set
				|| (pend_reg && run_en && !last && !start);
			ext_q_reg   <= ext_lvl;
			int_cnt_reg <= int_ev ? '0 : int_cnt_reg + 32'h1;
			if (last && arb_sel)
				seg_reg <= (seg_reg >= nseg - 4'h1)
					? '0 : seg_reg + 4'h1;
		end
	end

	// Output samples; zero whenever nothing is played.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			out_valid <= 1'b0;
			out_smp   <= '0;
		end
		else
		begin
			out_valid <= pop;
			out_smp   <= pop ? f_data : '0;
		end
	end

	assign seg_index = seg_reg;
	assign stat_val  = {state_reg, pend_reg, 9'h0, seg_reg, pos_reg};

	// ==============================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_IDLE_ZERO: assert property (
		state_reg == ST_IDLE |=> out_smp == '0 && !out_valid)
		else $error("Idle state produced output.");
	AST_GATE_HIGH: assert property (
		bb_gate && !gate_lo && !ext_trig |=> !out_valid)
		else $error("Output while high gate closed.");
	AST_GATE_LOW: assert property (
		gate_lo && ext_trig |=> out_smp == '0)
		else $error("Output while low gate closed.");
	AST_GATE_SRC: assert property (
		gate_mode |-> src == SRC_EXT)
		else $error("Gate mode left the external source.");
	AST_SINGLE: assert property (
		state_reg == ST_IDLE && bb_en && !arb_sel && bbm == BB_SINGLE
		&& src == SRC_EXT && ext_rise |=> state_reg == ST_PLAY)
		else $error("Rising edge did not start playback.");
	AST_WRAP: assert property (
		wrap && last && !restart |=> state_reg == ST_PLAY
		|| (gate_mode && state_reg == ST_GATED) || !run_en)
		else $error("Wrapping mode stopped after a pass.");
	AST_RESTART: assert property (
		arb_sel && arbm == ARB_CONT_RT && trig
		|=> state_reg == ST_PLAY && pos_reg == '0)
		else $error("Trigger did not restart playback.");
	AST_IGNORE: assert property (
		arb_sel && arbm == ARB_IGNORE && play_now && trig
		&& pos_reg != '0 && !last |=> pos_reg != '0)
		else $error("Ignored trigger restarted playback.");
	AST_BUFFER: assert property (
		buf_mode && pend_reg && last ##1 run_en
		|-> state_reg == ST_PLAY && pos_reg == '0)
		else $error("Buffered trigger was not replayed.");
	AST_RT_ABORT: assert property (
		arb_sel && arbm == ARB_SINGLE_RT && play_now && trig
		|=> pos_reg == '0 && state_reg == ST_PLAY)
		else $error("Realtime retrigger did not abort.");
	AST_SEGMENT: assert property (
		arb_sel && arbm == ARB_SEGMENT && last && nseg > 4'h1
		|=> state_reg == ST_IDLE && seg_reg != $past(seg_reg))
		else $error("Segment mode did not advance.");
	AST_ARB_GATE: assert property (
		arb_gate && !ext_trig && state_reg != ST_IDLE
		|=> state_reg == ST_GATED || !run_en)
		else $error("Arbitrary gate low did not stop.");
endmodule

/* File: tb.sv */
// Self-checking bench for the playback trigger block.
module tb
	import ptc_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;

	// One ordinary case: control word, trigger kind, count, gap, samples.
	typedef struct {
		logic [31:0] ctrl;
		int          kind, n, gap, exp, tol;
	} ptc_row_s;

	// ==============================================================
	// Signals
	logic        aclk = 0, aresetn = 0;
	logic [7:0]  awaddr = '0, araddr = '0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
	logic        rready = 0, key_press = 0, s_valid = 0, pulse_req = 0;
	logic        gate_on = 0, gate_low = 0;
	logic [31:0] wdata = '0;
	logic [3:0]  wstrb = 4'hf; // Whole words only.
	logic        awready, wready, bvalid, arready, rvalid, s_ready;
	logic        out_valid, ext_trig;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [3:0]  seg_index;
	ptc_smp_s    out_smp;
	logic [15:0] feed_cnt = '0, exp_i = '0; // Next sample fed, expected.
	int          num_errors = 0, num_checks = 0, n_out = 0;
	wire ptc_smp_s s_data = {feed_cnt, feed_cnt};

	// Kinds: 0 key, 1 ext pulse, 2/3 bus, 4 none, 5 gate, 6 low gate.
	ptc_row_s rows[14] = '{
		'{32'h45, 0, 1, 0, 8, 0},   // Single, key.
		'{32'h55, 1, 1, 0, 8, 0},   // Single, rising edge.
		'{32'h65, 2, 1, 0, 8, 0},   // Single, bus.
		'{32'h41, 4, 0, 0, 44, 3},  // Continuous, wraps.
		'{32'h09, 5, 1, 20, 20, 1}, // High gate, key source set.
		'{32'h0d, 6, 1, 20, 20, 1}, // Low gate.
		'{32'h1042, 1, 2, 4, 12, 1}, // Arb continuous realtime.
		'{32'h1142, 1, 2, 4, 8, 0},  // Arb ignore.
		'{32'h1242, 1, 2, 4, 16, 0}, // Arb buffered.
		'{32'h1342, 1, 2, 4, 12, 1}, // Arb single realtime.
		'{32'h0142, 0, 1, 0, 8, 0},  // Arb key.
		'{32'h2142, 3, 1, 0, 8, 0},  // Arb bus.
		'{32'h3142, 4, 0, 0, 16, 8}, // Arb internal, period 20.
		'{32'h0502, 5, 1, 20, 20, 1} // Arb high gate.
	};
	// Reset values of the registers, address above value.
	logic [39:0] rst_tab[6] = '{{OFS_CTRL, CTRL_RST},
		{OFS_BBLEN, 16'h0, BBLEN_RST}, {OFS_SEGLEN, 12'h0, SEGLEN_RST},
		{OFS_IPER, IPER_RST}, {OFS_TRIG, 32'h0}, {OFS_STAT, 32'h0}};

	// ==============================================================
	// Instances and clock
	always #5 aclk = !aclk;

	ptc_trigger i_ptc_trigger (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.key_press(key_press), .ext_trig(ext_trig), .s_valid(s_valid),
		.s_ready(s_ready), .s_data(s_data), .out_valid(out_valid),
		.out_smp(out_smp), .seg_index(seg_index));

	ptc_ext_src i_ptc_ext_src (.aclk(aclk), .pulse_req(pulse_req),
		.gate_on(gate_on), .gate_low(gate_low), .ext_trig(ext_trig));

	// ==============================================================
	// Tasks
	// Counts a comparison and reports it at once when it fails.
	task automatic chk(input bit ok, input string m);
		num_checks++;
		if (!ok)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask

	// Writes one word and compares the answer code; bready stays high.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		bit fa, fw;
		fa = 0;
		fw = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(fa && fw))
		begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1)
			begin
				fa = 1;
				awvalid <= 0;
			end
			if (wvalid && wready === 1'b1)
			begin
				fw = 1;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		if (bresp !== er) chk(0, "write answer");
		else chk(1, "");
	endtask

	// Reads one word and compares data and answer code; rready stays high.
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		if (rdata !== e || rresp !== er) chk(0, "read word");
		else chk(1, "");
	endtask

	// Issues the triggers or the gate window of one case.
	task automatic fire(input ptc_row_s r);
		for (int n = 0; n < r.n; n++)
		begin
			case (r.kind)
				0: begin key_press <= 1; @(posedge aclk); key_press <= 0; end
				1: begin pulse_req <= 1; @(posedge aclk); pulse_req <= 0; end
				2: wr(OFS_TRIG, 32'h1, RESP_OKAY);
				3: wr(OFS_TRIG, 32'h2, RESP_OKAY);
				default: begin gate_on <= 1; repeat (r.gap) @(posedge aclk);
					gate_on <= 0; end
			endcase
			if (r.kind == 1 && r.gap > 1)
				repeat (r.gap - 1) @(posedge aclk);
		end
	endtask

	// Runs one case from a full, idle FIFO and counts the samples.
	task automatic run_row(input ptc_row_s r);
		int c0, got;
		repeat (20) @(posedge aclk);
		if (s_ready !== 1'b0) chk(0, "fifo accepts while full");
		else chk(1, "");
		c0 = n_out;
		gate_low <= (r.kind == 6);
		wr(OFS_CTRL, r.ctrl, RESP_OKAY);
		fire(r);
		repeat (40) @(posedge aclk);
		wr(OFS_CTRL, 32'h0, RESP_OKAY);
		gate_low <= 0;
		got = n_out - c0;
		if (got < r.exp - r.tol || got > r.exp + r.tol) chk(0, "sample count");
		else chk(1, "");
		$display("case ctrl=%h done, %0d samples", r.ctrl, got);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ==============================================================
	// Stream feed and output monitor
	// The feed advances on every accepted word; order must survive.
	always @(posedge aclk)
	begin
		if (s_valid && s_ready === 1'b1)
			feed_cnt <= feed_cnt + 16'h1;
		if (aresetn && out_valid === 1'b1)
		begin
			n_out <= n_out + 1;
			exp_i <= exp_i + 16'h1;
			if (out_smp !== {exp_i, exp_i}) chk(0, "sample order");
		end
		else if (aresetn && out_smp !== '0) chk(0, "idle output");
	end

	// Cuts a hang short.
	initial
	begin
		#100000;
		num_errors++;
		$display("CHECK FAILED t=%0t watchdog", $time);
		report_and_stop;
	end

	// ==============================================================
	// Main sequence
	initial
	begin
		logic [3:0] s0;
		int c0;
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		foreach (rst_tab[k])
			rd(rst_tab[k][39:32], rst_tab[k][31:0], RESP_OKAY);
		rd(8'h18, 32'h0, RESP_SLVERR);
		wr(8'h18, 32'h5, RESP_SLVERR);
		wr(OFS_BBLEN, 32'h8, RESP_OKAY);
		wr(OFS_SEGLEN, 32'h2_0008, RESP_OKAY);
		wr(OFS_IPER, 32'd20, RESP_OKAY);
		rd(OFS_BBLEN, 32'h8, RESP_OKAY);
		$display("register test done");
		s_valid <= 1;
		foreach (rows[k])
			run_row(rows[k]);
		// Per-segment playback advances the segment on each trigger.
		wr(OFS_CTRL, 32'h1442, RESP_OKAY);
		s0 = seg_index;
		fire(rows[1]);
		repeat (30) @(posedge aclk);
		if (seg_index !== (s0 ^ 4'h1)) chk(0, "segment step");
		fire(rows[1]);
		repeat (30) @(posedge aclk);
		if (seg_index !== s0) chk(0, "segment wrap");
		wr(OFS_CTRL, 32'h0, RESP_OKAY);
		$display("segment test done");
		// A pass longer than the stalled FIFO drains it and then waits.
		s_valid <= 0;
		wr(OFS_BBLEN, 32'd20, RESP_OKAY);
		c0 = n_out;
		wr(OFS_CTRL, 32'h45, RESP_OKAY);
		fire(rows[0]);
		repeat (40) @(posedge aclk);
		if (n_out - c0 !== 16 || s_ready !== 1'b1) chk(0, "drain");
		s_valid <= 1;
		repeat (30) @(posedge aclk);
		if (n_out - c0 !== 20) chk(0, "pass resumes");
		wr(OFS_CTRL, 32'h0, RESP_OKAY);
		$display("drain test done");
		// A reset in mid-run empties the FIFO and restores the registers.
		s_valid <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		if (s_ready !== 1'b1 || out_valid !== 1'b0) chk(0, "after reset");
		exp_i <= feed_cnt;
		rd(OFS_CTRL, CTRL_RST, RESP_OKAY);
		$display("reset test done");
		report_and_stop;
	end
endmodule
